// ### tcmdbg_pkg.sv
// package: register selectors, field layout and reset values
package tcmdbg_pkg;

  // ****************************************************************
  // register selectors on the system coprocessor port
  // ****************************************************************
  localparam logic [2:0] SEL_INSTR_TCM_REGION      = 3'h0;
  localparam logic [2:0] SEL_POWER_CONTROL         = 3'h1;
  localparam logic [2:0] SEL_CACHE_DEBUG_OPERATION = 3'h2;
  localparam logic [2:0] SEL_DEBUG_DATA_LOW        = 3'h3;

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int BASE_MSB   = 31;
  localparam int BASE_LSB   = 12;
  localparam int SIZE_MSB   = 5;
  localparam int SIZE_LSB   = 2;
  localparam int EN_BIT     = 0;
  localparam int CG_BIT     = 0;
  localparam int WAY_MSB    = 31;
  localparam int WAY_LSB    = 30;
  localparam int TCM_BIT    = 22;
  localparam int RAM_BIT    = 21;
  localparam int SIDE_BIT   = 20;
  localparam int IDX_MSB    = 13;
  localparam int IDX_LSB    = 5;
  localparam int WORD_MSB   = 4;
  localparam int WORD_LSB   = 2;
  localparam int TADR_MSB   = 16;
  localparam int TADR_LSB   = 2;
  localparam int DIR_BIT    = 0;

  // ****************************************************************
  // reset values and size codes
  // ****************************************************************
  localparam logic [19:0] BASE_HIGH_VEC = 20'hFFFF0;
  localparam logic [19:0] BASE_LOW      = 20'h00000;
  localparam logic [3:0]  SIZE_RESET    = 4'h0;
  localparam logic [3:0]  SIZE_0KB      = 4'h0;
  localparam logic [3:0]  SIZE_4KB      = 4'h3;
  localparam logic [3:0]  SIZE_128KB    = 4'h8;
  localparam logic        EN_FIXED      = 1'h0;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        priv;
    logic [2:0]  sel;
    logic [31:0] wdata;
  } tcmdbg_cop_req_t;

  typedef struct packed {
    logic        start;
    logic        tcm;
    logic        data_ram;
    logic        instr_side;
    logic [1:0]  way;
    logic [8:0]  index;
    logic [2:0]  word;
    logic [14:0] tcm_addr;
    logic        write;
    logic [31:0] wdata;
  } tcmdbg_ram_req_t;

  typedef struct packed {
    logic [19:0] base;
    logic [3:0]  size;
    logic        size_valid;
    logic [5:0]  size_kb_log2;
    logic        enable;
  } tcmdbg_region_t;

endpackage : tcmdbg_pkg

// ### tcmdbg_regs.sv
// system-control registers: tcm region, power control, cache debug
`timescale 1ns/100ps

module tcmdbg_regs #(
  parameter bit ITCM_PRESENT = 1'b1,
  parameter bit DUAL_CORE    = 1'b1
) (
  // clock, reset, enable
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic                        clk_en,
  // straps from pins
  input  wire logic                        tcm_init_strap_p0,
  input  wire logic                        high_vector_strap_p0,
  input  wire logic                        tcm_init_strap_p1,
  input  wire logic                        high_vector_strap_p1,
  // system coprocessor access, processor 0 and processor 1
  input  wire tcmdbg_pkg::tcmdbg_cop_req_t cop_req,
  input  wire logic                        cop_core1,
  output logic [31:0]                      cop_rdata,
  output logic                             cop_rvalid,
  output logic                             cop_busy,
  // debug ram port
  output tcmdbg_pkg::tcmdbg_ram_req_t      ram_req,
  input  wire logic                        ram_done,
  input  wire logic [31:0]                 ram_rdata,
  // control outputs
  output tcmdbg_pkg::tcmdbg_region_t       region_p0,
  output tcmdbg_pkg::tcmdbg_region_t       region_p1,
  output logic                             clock_gate_en
);

  // ****************************************************************
  // strap synchronisers and release capture
  // ****************************************************************
  logic [3:0] strap_meta_reg;
  logic [3:0] strap_sync_reg;
  logic [1:0] rel_cnt_reg;
  logic       loaded_reg;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      strap_meta_reg <= 4'h0;
      strap_sync_reg <= 4'h0;
    end else if (clk_en) begin
      strap_meta_reg <= {high_vector_strap_p1, tcm_init_strap_p1,
                         high_vector_strap_p0, tcm_init_strap_p0};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // straps settle two edges after release; load them on the third
  // a low enable stretches the count so the load never hits a frozen edge
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rel_cnt_reg <= 2'h0;
    end else if (clk_en && rel_cnt_reg != 2'h3) begin
      rel_cnt_reg <= rel_cnt_reg + 2'h1;
    end
  end

  wire strap_load = clk_en && (rel_cnt_reg == 2'h2) && !loaded_reg;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      loaded_reg <= 1'b0;
    end else if (strap_load) begin
      loaded_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // access decode
  // ****************************************************************
  // a request while busy is dropped, not queued: software polls busy
  wire wr_en = clk_en && cop_req.wr && loaded_reg && !cop_busy;
  wire wr_itcm = wr_en && cop_req.priv &&
                 (cop_req.sel == tcmdbg_pkg::SEL_INSTR_TCM_REGION);
  wire wr_pwr  = wr_en &&
                 (cop_req.sel == tcmdbg_pkg::SEL_POWER_CONTROL);
  wire wr_dbg  = wr_en && cop_req.priv &&
                 (cop_req.sel == tcmdbg_pkg::SEL_CACHE_DEBUG_OPERATION);
  wire wr_dat  = wr_en && cop_req.priv &&
                 (cop_req.sel == tcmdbg_pkg::SEL_DEBUG_DATA_LOW);

  // ****************************************************************
  // instruction tcm region registers, one per processor
  // ****************************************************************
  logic [19:0] base_reg [2];
  logic [3:0]  size_reg [2];
  logic        en_reg   [2];

  for (genvar c = 0; c < 2; c++) begin : g_core
    wire init_s = strap_sync_reg[2*c];
    wire hvec_s = strap_sync_reg[2*c+1];
    wire wr_me  = wr_itcm && (cop_core1 == c[0]);
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        base_reg[c] <= tcmdbg_pkg::BASE_LOW;
        size_reg[c] <= tcmdbg_pkg::SIZE_RESET;
        en_reg[c]   <= tcmdbg_pkg::EN_FIXED;
      end else if (strap_load && (c == 0 || DUAL_CORE)) begin
        base_reg[c] <= (init_s && hvec_s) ? tcmdbg_pkg::BASE_HIGH_VEC
                                          : tcmdbg_pkg::BASE_LOW;
        en_reg[c]   <= ITCM_PRESENT ? init_s : tcmdbg_pkg::EN_FIXED;
      end else if (wr_me && (c == 0 || DUAL_CORE)) begin
        base_reg[c] <= cop_req.wdata[tcmdbg_pkg::BASE_MSB:
                                     tcmdbg_pkg::BASE_LSB];
        size_reg[c] <= cop_req.wdata[tcmdbg_pkg::SIZE_MSB:
                                     tcmdbg_pkg::SIZE_LSB];
        if (ITCM_PRESENT) begin
          en_reg[c] <= cop_req.wdata[tcmdbg_pkg::EN_BIT];
        end
      end
    end
  end

  // size code to log2 of bytes; reserved codes flagged invalid
  function automatic tcmdbg_pkg::tcmdbg_region_t decode_region(
      input logic [19:0] base, input logic [3:0] size, input logic en);
    tcmdbg_pkg::tcmdbg_region_t r;
    r.base = base;
    r.size = size;
    r.enable = en;
    r.size_valid = (size == tcmdbg_pkg::SIZE_0KB) ||
                   ((size >= tcmdbg_pkg::SIZE_4KB) &&
                    (size <= tcmdbg_pkg::SIZE_128KB));
    r.size_kb_log2 = (r.size_valid && size != tcmdbg_pkg::SIZE_0KB)
                     ? {2'h0, size} + 6'h9 : 6'h0;
    return r;
  endfunction

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      region_p0 <= '0;
      region_p1 <= '0;
    end else if (clk_en) begin
      region_p0 <= decode_region(base_reg[0], size_reg[0], en_reg[0]);
      region_p1 <= decode_region(base_reg[1], size_reg[1], en_reg[1]);
    end
  end

  // ****************************************************************
  // power control
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clock_gate_en <= 1'b0;
    end else if (wr_pwr) begin
      clock_gate_en <= cop_req.wdata[tcmdbg_pkg::CG_BIT];
    end
  end

  // ****************************************************************
  // debug operation and data register
  // ****************************************************************
  logic [31:0] dbg_data_reg;

  // tcm layout reuses the cache bit positions: qualify every field except write and
  // instr_side by the layout bit so no other cache field leaks into a tcm access
  logic        op_tcm;
  logic        op_data_ram;
  logic [1:0]  op_way;
  logic [8:0]  op_index;
  logic [2:0]  op_word;
  logic [14:0] op_tcm_addr;

  always_comb begin
    op_tcm      = cop_req.wdata[tcmdbg_pkg::TCM_BIT];
    op_data_ram = !op_tcm && cop_req.wdata[tcmdbg_pkg::RAM_BIT];
    op_way      = 2'h0;
    op_index    = 9'h000;
    op_word     = 3'h0;
    op_tcm_addr = 15'h0000;
    if (op_tcm) begin
      op_tcm_addr = cop_req.wdata[tcmdbg_pkg::TADR_MSB:
                                  tcmdbg_pkg::TADR_LSB];
    end else begin
      op_way   = cop_req.wdata[tcmdbg_pkg::WAY_MSB:
                               tcmdbg_pkg::WAY_LSB];
      op_index = cop_req.wdata[tcmdbg_pkg::IDX_MSB:
                               tcmdbg_pkg::IDX_LSB];
    end
    // word select means nothing to a tag access
    if (op_data_ram) begin
      op_word = cop_req.wdata[tcmdbg_pkg::WORD_MSB:
                              tcmdbg_pkg::WORD_LSB];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ram_req <= '0;
    end else if (clk_en) begin
      if (wr_dbg) begin
        ram_req.start      <= 1'b1;
        ram_req.tcm        <= op_tcm;
        ram_req.data_ram   <= op_data_ram;
        ram_req.instr_side <= cop_req.wdata[tcmdbg_pkg::SIDE_BIT];
        ram_req.way        <= op_way;
        ram_req.index      <= op_index;
        ram_req.word       <= op_word;
        ram_req.tcm_addr   <= op_tcm_addr;
        ram_req.write      <= cop_req.wdata[tcmdbg_pkg::DIR_BIT];
        ram_req.wdata      <= dbg_data_reg;
      end else begin
        ram_req.start <= 1'b0;
      end
    end
  end

  // busy from launch until the ram reports done; stalls all accesses
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cop_busy <= 1'b0;
    end else if (clk_en) begin
      if (wr_dbg) begin
        cop_busy <= 1'b1;
      end else if (ram_done) begin
        cop_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dbg_data_reg <= 32'h00000000;
    end else if (clk_en) begin
      if (cop_busy && ram_done && !ram_req.write) begin
        dbg_data_reg <= ram_rdata;
      end else if (wr_dat) begin
        dbg_data_reg <= cop_req.wdata;
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [31:0] rd_mux;
  wire         c1 = cop_core1 && DUAL_CORE;

  always_comb begin
    rd_mux = 32'h00000000;
    case (cop_req.sel)
      tcmdbg_pkg::SEL_INSTR_TCM_REGION: begin
        rd_mux = {base_reg[c1], 6'h00, size_reg[c1], 1'b0, en_reg[c1]};
      end
      tcmdbg_pkg::SEL_POWER_CONTROL: begin
        rd_mux = {31'h00000000, clock_gate_en};
      end
      // write-only: launch fields are never read back
      tcmdbg_pkg::SEL_CACHE_DEBUG_OPERATION: begin
        rd_mux = 32'h00000000;
      end
      tcmdbg_pkg::SEL_DEBUG_DATA_LOW: begin
        rd_mux = dbg_data_reg;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  wire rd_en = clk_en && cop_req.rd && loaded_reg && !cop_busy &&
               (cop_req.priv ||
                cop_req.sel == tcmdbg_pkg::SEL_POWER_CONTROL);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cop_rdata  <= 32'h00000000;
      cop_rvalid <= 1'b0;
    end else if (clk_en) begin
      cop_rvalid <= rd_en;
      cop_rdata  <= rd_en ? rd_mux : 32'h00000000;
    end
  end

endmodule // tcmdbg_regs

// ### tcmdbg_assertions.sv
// checker: port-level properties of the tcm and debug register block
`timescale 1ns/100ps
module tcmdbg_assertions (
  // clock and reset
  input wire logic                        clk_sys,
  input wire logic                        reset,
  input wire logic                        clk_en,
  // coprocessor port
  input wire tcmdbg_pkg::tcmdbg_cop_req_t cop_req,
  input wire logic [31:0]                 cop_rdata,
  input wire logic                        cop_rvalid,
  input wire logic                        cop_busy,
  // debug ram port and gate
  input wire tcmdbg_pkg::tcmdbg_ram_req_t ram_req,
  input wire logic                        ram_done,
  input wire logic                        clock_gate_en
);
  // ****
  // helpers
  // ****
  logic [2:0]  age;
  logic [31:0] wq;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  always_ff @(posedge clk_sys) begin
    wq <= cop_req.wdata;
  end
  // wide margin after reset: strap loading is not judged here
  wire go = (age == 3'h7) && clk_en && !cop_busy;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_op_wr;
    go && cop_req.wr && cop_req.priv && cop_req.sel == 3'h2;
  endsequence
  sequence s_cache_op;
    s_op_wr ##0 !cop_req.wdata[22];
  endsequence
  a_priv_launch: assert property (s_op_wr |=> ram_req.start && cop_busy)
    else $error("debug op write did not launch");
  a_user_blocked: assert property (go && cop_req.wr && !cop_req.priv &&
    cop_req.sel == 3'h2 |=> !ram_req.start) else $error("user launch");
  a_one_start: assert property (ram_req.start |=> !ram_req.start)
    else $error("start longer than one cycle");
  a_cache_fields: assert property (s_cache_op |=> !ram_req.tcm &&
    ram_req.way == wq[31:30] && ram_req.data_ram == wq[21] &&
    ram_req.instr_side == wq[20] && ram_req.write == wq[0])
    else $error("cache op fields wrong");
  a_index_word: assert property (s_cache_op |=> ram_req.index == wq[13:5] &&
    ram_req.word == (wq[21] ? wq[4:2] : 3'h0)) else $error("index or word");
  a_tcm_fields: assert property (s_op_wr ##0 cop_req.wdata[22] |=>
    ram_req.tcm && ram_req.tcm_addr == wq[16:2] && ram_req.way == 2'h0)
    else $error("tcm op fields wrong");
  a_busy_clear: assert property (clk_en && cop_busy && ram_done |=>
    !cop_busy) else $error("busy stuck after done");
  a_gate_write: assert property (go && cop_req.wr && cop_req.sel == 3'h1
    |=> clock_gate_en == wq[0]) else $error("gate not written");
  a_op_raz: assert property (go && cop_req.rd && cop_req.priv &&
    cop_req.sel == 3'h2 |=> cop_rvalid && cop_rdata == 32'h0)
    else $error("debug op reg not read as zero");
endmodule // tcmdbg_assertions

// ### test_tcmdbg_regs.sv
// testbench: directed tests of the tcm and debug register block
`timescale 1ns/100ps
module test_tcmdbg_regs;
  // ****
  // signals
  // ****
  logic clk_sys = 1'h0, reset = 1'h1, clk_en = 1'h1, core1 = 1'h0;
  logic init0 = 1'h0, hv0 = 1'h0, init1 = 1'h0, hv1 = 1'h0;
  logic ram_done = 1'h0, cop_rvalid, cop_busy, gate;
  logic [31:0] ram_rdata = 32'h0, rd, cop_rdata;
  tcmdbg_pkg::tcmdbg_cop_req_t cop_req = '0;
  tcmdbg_pkg::tcmdbg_ram_req_t ram_req;
  tcmdbg_pkg::tcmdbg_region_t  r0, r1;
  int err_total = 0, n_checks = 0, cyc = 0;
  tcmdbg_regs dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
    .tcm_init_strap_p0(init0), .high_vector_strap_p0(hv0),
    .tcm_init_strap_p1(init1), .high_vector_strap_p1(hv1),
    .cop_req(cop_req), .cop_core1(core1), .cop_rdata(cop_rdata),
    .cop_rvalid(cop_rvalid), .cop_busy(cop_busy), .ram_req(ram_req),
    .ram_done(ram_done), .ram_rdata(ram_rdata), .region_p0(r0),
    .region_p1(r1), .clock_gate_en(gate));
  initial forever #12.5 clk_sys = ~clk_sys;
  // whole run is well under 2000 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      stop_test;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one-cycle request; answer sampled after the taking edge
  task automatic cop(input logic w, r, p, input logic [2:0] s,
                     input logic [31:0] d);
    @(negedge clk_sys);
    cop_req = '{wr:w, rd:r, priv:p, sel:s, wdata:d};
    @(negedge clk_sys);
    cop_req = '0;
    rd = cop_rvalid ? cop_rdata : 32'hDEADBEEF;
  endtask
  task automatic do_reset(input logic [3:0] st);
    {init0, hv0, init1, hv1} = st;
    reset = 1'h1;
    repeat (4) @(negedge clk_sys);
    reset = 1'h0;
    repeat (6) @(negedge clk_sys);
  endtask
  task automatic t_straps;
    do_reset(4'hE);
    chk(r0.base, 20'hFFFF0);
    chk(r0.enable, 1'h1);
    chk(r1.base, 20'h0);
    chk(r1.enable, 1'h1);
    chk(gate, 1'h0);
    cop(0, 1, 1, 3'h0, 32'h0);
    chk(rd, 32'hFFFF0001);
    do_reset(4'h3);
    chk(r1.base, 20'hFFFF0);
    chk(r0.base, 20'h0);
    chk(r0.enable, 1'h0);
    $display("test straps done");
  endtask
  task automatic t_region;
    for (int c = 0; c < 16; c++) begin
      cop(1, 0, 1, 3'h0, {20'hABCDE, 6'h0, c[3:0], 2'h1});
      @(negedge clk_sys);
      chk(r0.size_valid, c == 0 || (c >= 3 && c <= 8));
      chk(r0.size_kb_log2, (c >= 3 && c <= 8) ? c + 9 : 0);
    end
    cop(1, 0, 1, 3'h0, 32'hABCDE021);
    cop(1, 0, 0, 3'h0, 32'h0);
    cop(0, 1, 1, 3'h0, 32'h0);
    chk(rd, 32'hABCDE021);
    cop(0, 1, 0, 3'h0, 32'h0);
    chk(rd, 32'hDEADBEEF);
    core1 = 1'h1;
    cop(1, 0, 1, 3'h0, 32'h12345001);
    core1 = 1'h0;
    @(negedge clk_sys);
    chk(r1.base, 20'h12345);
    chk(r0.base, 20'hABCDE);
    $display("test region done");
  endtask
  task automatic t_power;
    cop(1, 0, 0, 3'h1, 32'hFFFFFFFF);
    chk(gate, 1'h1);
    cop(0, 1, 0, 3'h1, 32'h0);
    chk(rd, 32'h1);
    clk_en = 1'h0;
    cop(1, 0, 0, 3'h1, 32'h0);
    chk(gate, 1'h1);
    clk_en = 1'h1;
    cop(1, 0, 0, 3'h1, 32'h0);
    chk(gate, 1'h0);
    $display("test power done");
  endtask
  task automatic dbg(input logic [31:0] op, input logic [31:0] ret);
    cop(1, 0, 1, 3'h2, op);
    chk({ram_req.start, cop_busy}, 2'h3);
    @(negedge clk_sys);
    chk(ram_req.start, 1'h0);
    ram_done = 1'h1;
    ram_rdata = ret;
    @(negedge clk_sys);
    ram_done = 1'h0;
    chk(cop_busy, 1'h0);
  endtask
  task automatic t_debug;
    for (int w = 0; w < 4; w++) begin
      dbg({w[1:0], 8'h0, 1'h1, w[0], 6'h0, 9'h155, 3'h5, 1'h0, w[1]},
          32'h0);
      chk(ram_req.way, w[1:0]);
      chk({ram_req.tcm, ram_req.data_ram}, 2'h1);
      chk(ram_req.instr_side, w[0]);
      chk(ram_req.index, 9'h155);
      chk(ram_req.word, 3'h5);
      chk(ram_req.write, w[1]);
    end
    dbg({12'h0, 6'h0, 9'h0AA, 3'h5, 2'h0}, 32'hCAFE1234);
    chk({ram_req.data_ram, ram_req.word}, 4'h0);
    cop(0, 1, 1, 3'h3, 32'h0);
    chk(rd, 32'hCAFE1234);
    cop(1, 0, 1, 3'h3, 32'h600DF00D);
    dbg({9'h0, 3'h4, 3'h0, 15'h5A5A, 2'h1}, 32'h0);
    chk(ram_req.tcm_addr, 15'h5A5A);
    chk({ram_req.tcm, ram_req.write}, 2'h3);
    chk(ram_req.wdata, 32'h600DF00D);
    cop(1, 0, 0, 3'h2, 32'h1);
    chk({ram_req.start, cop_busy}, 2'h0);
    cop(0, 1, 1, 3'h2, 32'h0);
    chk(rd, 32'h0);
    $display("test debug done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    t_straps;
    t_region;
    t_power;
    t_debug;
    stop_test;
  end
endmodule // test_tcmdbg_regs
bind tcmdbg_regs tcmdbg_assertions u_chk (.clk_sys(clk_sys),
  .reset(reset), .clk_en(clk_en), .cop_req(cop_req),
  .cop_rdata(cop_rdata), .cop_rvalid(cop_rvalid), .cop_busy(cop_busy),
  .ram_req(ram_req), .ram_done(ram_done), .clock_gate_en(clock_gate_en));
